// file: core/host_ec_mailbox.v
`timescale 1ns/100ps
`default_nettype none

`include "host_ec_mailbox_regs.vh"

// Functional notes
// - 36 indexed byte registers, four for signalling
// - 32 mailbox bytes shared by both sides
// - host port: index byte and data byte
// - controller may also use the host port
// - serial irq source equals enabled posted flag
// - alert on any enabled software alert bit
// - enabled posted flag also raises the alert
// - alert goes to pin and irq frame
// - alert appears active low toward irq stream
// - alert drives open-drain pin low
// - host command write raises controller irq
// - controller writing ffh clears host command
// - controller command write may alert host
// - host writing ffh clears controller command
// - single clock for all mailbox logic
// - system reset restores every register
// - host port held reset without main power
// - idle block enters low power automatically
// - controller read of host command clears irq
// - data port reaches currently indexed register
module host_ec_mailbox (
    input  wire        sys_clk,                   // single block clock
    input  wire        resetn,                    // system reset, synchronous, active low
    input  wire        main_power_good,           // main rail good, asynchronous level
    input  wire        host_wr,                   // host port write strobe
    input  wire        host_rd,                   // host port read strobe
    input  wire        host_addr,                 // 0 index port, 1 data port
    input  wire [7:0]  host_wdata,                // host write byte
    output reg  [7:0]  host_rdata,                // host read byte
    output reg         host_rvalid,               // host read data valid pulse
    input  wire        ec_we,                     // controller write strobe
    input  wire        ec_rd,                     // controller read strobe
    input  wire [8:0]  ec_addr,                   // controller byte address
    input  wire [3:0]  ec_be,                     // controller byte enables
    input  wire [31:0] ec_wdata,                  // controller write word
    output reg  [31:0] ec_rdata,                  // controller read word
    output reg         ec_rvalid,                 // controller read data valid pulse
    input  wire        controller_irq_enable,     // unmask for controller irq
    input  wire        alert_pin_select,          // pin control selects alert function
    output reg         controller_command_irq,    // controller mailbox interrupt
    output reg         host_serial_irq_source,    // serial irq source, active high
    output reg         host_mgmt_alert_source,    // management alert source, active high
    output reg         mgmt_alert_serirq_n,       // alert frame level, active low
    output reg         system_mgmt_alert_pin_out, // open-drain pin output value
    output reg         system_mgmt_alert_pin_oe,  // pin driven while high
    output reg         block_idle                 // no access in progress
);

    reg  [7:0] host_index_port;
    reg  [7:0] h2ec_cmd;
    reg  [7:0] ec2h_cmd;
    reg        controller_posted_flag;
    reg        controller_posted_enable;
    reg  [6:0] software_alert_bits;
    reg  [6:0] software_alert_enables;
    reg        cmd_irq_flag;
    reg  [7:0] mbox [0:31];                       // shared mailbox bytes
    reg  [7:0] idx_val;
    reg  [31:0] ec_val;
    wire       pg_ok;
    integer    i;

    // main power good crosses in from its own rail
    sync2_level u_pg_sync (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .async_in (main_power_good),
        .sync_out (pg_ok)
    );

    // controller may reach the host port at word 0; host strobes take priority
    wire [8:0] ec_wa   = {ec_addr[8:2], 2'b00};
    wire       ec_rt   = ~host_wr & ~host_rd & (ec_wa == `BOX_EC_RT_PORT);

    // unified host port strobes, all blocked while main power is down
    wire hp_wr_index = pg_ok & ((host_wr & (host_addr == `BOX_RT_INDEX)) |
                                (ec_rt & ec_we & ec_be[0]));
    wire hp_wr_data  = pg_ok & ((host_wr & (host_addr == `BOX_RT_DATA)) |
                                (ec_rt & ec_we & ec_be[1]));
    wire [7:0] hp_wd_index = host_wr ? host_wdata : ec_wdata[7:0];
    wire [7:0] hp_wd_data  = host_wr ? host_wdata : ec_wdata[15:8];

    // host data port writes decoded by the current index
    wire hw_h2ec = hp_wr_data & (host_index_port == `BOX_IDX_H2EC);
    wire hw_ec2h = hp_wr_data & (host_index_port == `BOX_IDX_EC2H);
    wire hw_src  = hp_wr_data & (host_index_port == `BOX_IDX_SRC);
    wire hw_mask = hp_wr_data & (host_index_port == `BOX_IDX_MASK);
    wire hw_mbox = hp_wr_data & (host_index_port >= `BOX_IDX_MBOX_FIRST) &
                   (host_index_port <= `BOX_IDX_MBOX_LAST);
    wire [7:0] h_msub = host_index_port - `BOX_IDX_MBOX_FIRST;
    wire [4:0] h_mi   = h_msub[4:0];

    // controller register strobes at their own offsets
    wire ew_h2ec = ec_we & (ec_wa == `BOX_EC_H2EC) & ec_be[0];
    wire er_h2ec = ec_rd & (ec_wa == `BOX_EC_H2EC);
    wire ew_ec2h = ec_we & (ec_wa == `BOX_EC_EC2H) & ec_be[0];
    wire ew_src  = ec_we & (ec_wa == `BOX_EC_SRC)  & ec_be[0];
    wire ew_mask = ec_we & (ec_wa == `BOX_EC_MASK) & ec_be[0];
    wire e_mbox  = (ec_wa >= `BOX_EC_MBOX_FIRST) & (ec_wa <= `BOX_EC_MBOX_LAST);
    wire [8:0] e_msub = ec_wa - `BOX_EC_MBOX_FIRST;
    wire [2:0] e_mw   = e_msub[4:2];

    // alert terms feed the flops that drive the outputs
    wire posted_evt   = controller_posted_flag & controller_posted_enable;
    wire swi_evt      = |(software_alert_bits & software_alert_enables);
    wire alert_evt    = swi_evt | posted_evt;

    // next values of the hardware-set flags; set beats clear in the same cycle
    wire next_posted  = ew_ec2h |
                        (controller_posted_flag &
                         ~(hw_src & hp_wd_data[`BOX_POSTED_BIT]) &
                         ~(hw_ec2h & (hp_wd_data == `BOX_DONE_CODE)));
    wire [6:0] swi_set   = ew_src ? ec_wdata[`BOX_SWI_MSB:`BOX_SWI_LSB] : 7'h00;
    wire [6:0] swi_clr   = hw_src ? hp_wd_data[`BOX_SWI_MSB:`BOX_SWI_LSB] : 7'h00;
    wire [6:0] next_swi  = (software_alert_bits & ~swi_clr) | swi_set;
    wire next_cmd_irq    = hw_h2ec | (cmd_irq_flag & ~er_h2ec);

    // indexed read value; unmapped indexes read as zero
    always @* begin
        idx_val = `BOX_RST_BYTE;
        case (host_index_port)
            `BOX_IDX_H2EC: begin
                idx_val = h2ec_cmd;
            end
            `BOX_IDX_EC2H: begin
                idx_val = ec2h_cmd;
            end
            `BOX_IDX_SRC: begin
                idx_val = {software_alert_bits, controller_posted_flag};
            end
            `BOX_IDX_MASK: begin
                idx_val = {software_alert_enables, controller_posted_enable};
            end
            default: begin
                if ((host_index_port >= `BOX_IDX_MBOX_FIRST) &&
                    (host_index_port <= `BOX_IDX_MBOX_LAST)) begin
                    idx_val = mbox[h_mi];
                end else begin
                    idx_val = `BOX_RST_BYTE;
                end
            end
        endcase
    end

    // controller read word; unmapped offsets read as zero
    always @* begin
        ec_val = `BOX_RST_WORD;
        case (ec_wa)
            `BOX_EC_RT_PORT: begin
                ec_val = {16'h0000, (pg_ok ? idx_val : 8'h00), host_index_port};
            end
            `BOX_EC_H2EC: begin
                ec_val = {24'h000000, h2ec_cmd};
            end
            `BOX_EC_EC2H: begin
                ec_val = {24'h000000, ec2h_cmd};
            end
            `BOX_EC_SRC: begin
                ec_val = {24'h000000, software_alert_bits, controller_posted_flag};
            end
            `BOX_EC_MASK: begin
                ec_val = {24'h000000, software_alert_enables, controller_posted_enable};
            end
            default: begin
                if (e_mbox) begin
                    ec_val = {mbox[{e_mw, 2'b11}], mbox[{e_mw, 2'b10}],
                              mbox[{e_mw, 2'b01}], mbox[{e_mw, 2'b00}]};
                end else begin
                    ec_val = `BOX_RST_WORD;
                end
            end
        endcase
    end

    // host access port index; cleared whenever main power is absent
    always @(posedge sys_clk) begin
        if (!resetn) begin
            host_index_port <= `BOX_RST_BYTE;
        end else if (!pg_ok) begin
            host_index_port <= `BOX_RST_BYTE;
        end else if (hp_wr_index) begin
            host_index_port <= hp_wd_index;
        end
    end

    // command registers; simultaneous writes: host wins h2ec, controller wins ec2h, software must avoid it
    always @(posedge sys_clk) begin
        if (!resetn) begin
            h2ec_cmd <= `BOX_RST_BYTE;
            ec2h_cmd <= `BOX_RST_BYTE;
        end else begin
            if (hw_h2ec) begin
                h2ec_cmd <= hp_wd_data;
            end else if (ew_h2ec) begin
                // each 1 clears its bit, so ffh returns the register to 00h
                h2ec_cmd <= h2ec_cmd & ~ec_wdata[7:0];
            end
            if (ew_ec2h) begin
                ec2h_cmd <= ec_wdata[7:0];
            end else if (hw_ec2h) begin
                if (hp_wd_data == `BOX_DONE_CODE) begin
                    ec2h_cmd <= `BOX_CLEAR_CODE;
                end else begin
                    ec2h_cmd <= hp_wd_data;
                end
            end
        end
    end

    // signalling flags and enables
    always @(posedge sys_clk) begin
        if (!resetn) begin
            controller_posted_flag   <= 1'b0;
            controller_posted_enable <= 1'b0;
            software_alert_bits      <= 7'h00;
            software_alert_enables   <= 7'h00;
            cmd_irq_flag             <= 1'b0;
        end else begin
            controller_posted_flag <= next_posted;
            software_alert_bits    <= next_swi;
            cmd_irq_flag           <= next_cmd_irq;
            if (ew_mask) begin
                controller_posted_enable <= ec_wdata[`BOX_POSTED_BIT];
                software_alert_enables   <= ec_wdata[`BOX_SWI_MSB:`BOX_SWI_LSB];
            end else if (hw_mask) begin
                controller_posted_enable <= hp_wd_data[`BOX_POSTED_BIT];
                software_alert_enables   <= hp_wd_data[`BOX_SWI_MSB:`BOX_SWI_LSB];
            end
        end
    end

    // shared mailbox bytes; a controller byte to the same slot lands after the host's
    always @(posedge sys_clk) begin
        if (!resetn) begin
            for (i = 0; i < 32; i = i + 1) begin
                mbox[i] <= `BOX_RST_BYTE;
            end
        end else begin
            if (hw_mbox) begin
                mbox[h_mi] <= hp_wd_data;
            end
            if (ec_we && e_mbox) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (ec_be[i]) begin
                        mbox[{e_mw, i[1:0]}] <= ec_wdata[8*i +: 8];
                    end
                end
            end
        end
    end

    // read data only moves on a read, so an idle port does not toggle
    always @(posedge sys_clk) begin
        if (!resetn) begin
            host_rdata  <= `BOX_RST_BYTE;
            host_rvalid <= 1'b0;
            ec_rdata    <= `BOX_RST_WORD;
            ec_rvalid   <= 1'b0;
        end else begin
            host_rvalid <= host_rd;
            ec_rvalid   <= ec_rd;
            if (host_rd) begin
                if (!pg_ok) begin
                    host_rdata <= `BOX_RST_BYTE;
                end else if (host_addr == `BOX_RT_INDEX) begin
                    host_rdata <= host_index_port;
                end else begin
                    host_rdata <= idx_val;
                end
            end
            if (ec_rd) begin
                ec_rdata <= ec_val;
            end
        end
    end

    // interrupt and alert outputs, all registered
    always @(posedge sys_clk) begin
        if (!resetn) begin
            controller_command_irq    <= 1'b0;
            host_serial_irq_source    <= 1'b0;
            host_mgmt_alert_source    <= 1'b0;
            mgmt_alert_serirq_n       <= 1'b1;
            system_mgmt_alert_pin_out <= 1'b1;
            system_mgmt_alert_pin_oe  <= 1'b0;
            block_idle                <= 1'b1;
        end else begin
            controller_command_irq    <= cmd_irq_flag & controller_irq_enable;
            host_serial_irq_source    <= posted_evt;
            host_mgmt_alert_source    <= alert_evt;
            mgmt_alert_serirq_n       <= ~alert_evt;
            // open drain: only ever pulls low, released otherwise
            system_mgmt_alert_pin_out <= ~alert_evt;
            system_mgmt_alert_pin_oe  <= alert_evt & alert_pin_select;
            // no strobe means no flop but the flags changes: the block rests by itself
            block_idle <= ~(host_wr | host_rd | ec_we | ec_rd);
        end
    end

endmodule

`default_nettype wire

// file: core/host_ec_mailbox_regs.vh
`ifndef HOST_EC_MAILBOX_REGS_VH
`define HOST_EC_MAILBOX_REGS_VH

// host access port offsets (one address bit)
`define BOX_RT_INDEX        1'b0
`define BOX_RT_DATA         1'b1

// host indexes of the signalling registers and the mailbox byte range
`define BOX_IDX_H2EC        8'h00
`define BOX_IDX_EC2H        8'h01
`define BOX_IDX_SRC         8'h02
`define BOX_IDX_MASK        8'h03
`define BOX_IDX_MBOX_FIRST  8'h10
`define BOX_IDX_MBOX_LAST   8'h2f

// controller byte offsets, one 32-bit word each, registers in lane 0, host data port in lane 1, mailbox words in all four lanes
`define BOX_EC_RT_PORT      9'h000
`define BOX_EC_H2EC         9'h100
`define BOX_EC_EC2H         9'h104
`define BOX_EC_SRC          9'h108
`define BOX_EC_MASK         9'h10c
`define BOX_EC_MBOX_FIRST   9'h110
`define BOX_EC_MBOX_LAST    9'h12c

// field positions in source and mask registers
`define BOX_POSTED_BIT      0
`define BOX_SWI_MSB         7
`define BOX_SWI_LSB         1

// command completion handshake values
`define BOX_DONE_CODE       8'hff
`define BOX_CLEAR_CODE      8'h00

// reset values
`define BOX_RST_BYTE        8'h00
`define BOX_RST_WORD        32'h0000_0000

`endif

// file: core/mbx_sync2.v
`timescale 1ns/100ps
`default_nettype none

// two-flop level synchroniser; first stage feeds only the second
module sync2_level (
    input  wire sys_clk,   // block clock
    input  wire resetn,    // synchronous reset, active low
    input  wire async_in,  // level from another domain
    output reg  sync_out   // synchronised level
);

    reg meta;

    // constant reset values only; the strap-like input is caught after release
    always @(posedge sys_clk) begin
        if (!resetn) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// file: tb/host_ec_mailbox_props.sv
`timescale 1ns/100ps
`default_nettype none
// port-level properties of the mailbox, bound below
module host_ec_mailbox_props (
    input wire logic       sys_clk, // clock
    input wire logic       resetn, // reset, low
    input wire logic       main_power_good, // rail good
    input wire logic       host_wr, // host write
    input wire logic       host_rd, // host read
    input wire logic [7:0] host_rdata, // host byte
    input wire logic       host_rvalid, // host valid
    input wire logic       ec_we, // ctrl write
    input wire logic       ec_rd, // ctrl read
    input wire logic [8:0] ec_addr, // ctrl address
    input wire logic       ec_rvalid, // ctrl valid
    input wire logic       controller_irq_enable, // irq unmask
    input wire logic       alert_pin_select, // pin function
    input wire logic       controller_command_irq, // ctrl irq
    input wire logic       host_serial_irq_source, // serirq source
    input wire logic       host_mgmt_alert_source, // alert source
    input wire logic       mgmt_alert_serirq_n, // frame level
    input wire logic       system_mgmt_alert_pin_out, // pin value
    input wire logic       system_mgmt_alert_pin_oe, // pin drive
    input wire logic       block_idle // idle flag
);
    // any strobe this cycle, so $past sees a plain signal
    wire any_strobe = host_wr | host_rd | ec_we | ec_rd;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // answers land exactly one edge after their strobe
    a_host_rvalid_pulse: assert property (host_rvalid == $past(host_rd))
        else $error("host read valid off by a cycle");
    a_ec_rvalid_pulse: assert property (ec_rvalid == $past(ec_rd))
        else $error("controller read valid off by a cycle");
    a_idle_after_quiet: assert property (block_idle == !$past(any_strobe))
        else $error("idle flag disagrees with strobes");
    // every alert output derives from the one alert level
    a_frame_level_inverse: assert property (
        mgmt_alert_serirq_n == !host_mgmt_alert_source)
        else $error("frame level not inverse of alert");
    a_pin_drives_low: assert property (
        system_mgmt_alert_pin_oe |-> !system_mgmt_alert_pin_out)
        else $error("alert pin driven but not low");
    a_pin_needs_select: assert property (
        system_mgmt_alert_pin_oe |-> host_mgmt_alert_source && $past(alert_pin_select))
        else $error("alert pin driven without cause");
    a_serirq_means_alert: assert property (
        host_serial_irq_source |-> host_mgmt_alert_source)
        else $error("posted event without alert");
    a_irq_needs_enable: assert property (
        controller_command_irq |-> $past(controller_irq_enable))
        else $error("controller irq while masked");
    // a host write in the read cycle may set the flag again
    a_irq_read_clear: assert property (
        ec_rd && ec_addr[8:2] == 7'h40 && !host_wr |=> ##1 !controller_command_irq)
        else $error("controller irq survives command read");
    // two synchroniser stages, then the port is held
    a_unpowered_reads_zero: assert property (
        host_rvalid && !$past(main_power_good, 2) && !$past(main_power_good, 3)
        |-> host_rdata == 8'h00)
        else $error("host read nonzero without main power");
    c_cmd_irq: cover property (controller_command_irq);
    c_pin_driven: cover property (system_mgmt_alert_pin_oe);
    c_unpowered_read: cover property (host_rvalid && !main_power_good);
endmodule

bind host_ec_mailbox host_ec_mailbox_props host_ec_mailbox_props_inst (
    .sys_clk(sys_clk), .resetn(resetn), .main_power_good(main_power_good),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .ec_we(ec_we), .ec_rd(ec_rd), .ec_addr(ec_addr), .ec_rvalid(ec_rvalid),
    .controller_irq_enable(controller_irq_enable), .alert_pin_select(alert_pin_select),
    .controller_command_irq(controller_command_irq),
    .host_serial_irq_source(host_serial_irq_source),
    .host_mgmt_alert_source(host_mgmt_alert_source), .mgmt_alert_serirq_n(mgmt_alert_serirq_n),
    .system_mgmt_alert_pin_out(system_mgmt_alert_pin_out),
    .system_mgmt_alert_pin_oe(system_mgmt_alert_pin_oe), .block_idle(block_idle));
`default_nettype wire

// file: tb/host_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// host processor on the index/data port, one access at a time
module host_cpu_model (
    input  wire logic       sys_clk, // block clock
    input  wire logic [7:0] host_rdata, // read byte
    input  wire logic       host_rvalid, // read valid
    output var  logic       host_wr, // write strobe
    output var  logic       host_rd, // read strobe
    output var  logic       host_addr, // 0 index, 1 data
    output var  logic [7:0] host_wdata // write byte
);
    initial begin
        {host_wr, host_rd, host_addr, host_wdata} = 11'h000;
    end
    // one strobed cycle; data is scrambled afterwards so nothing relies on it
    task automatic cyc(input logic wr, input logic a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        {host_wr, host_rd, host_addr, host_wdata} = {wr, !wr, a, d};
        @(posedge sys_clk);
        #1;
        {host_wr, host_rd, host_wdata} = {2'b00, ~d};
    endtask
    // serialised accesses keep the two sides off the command bytes at once
    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        cyc(1'b1, 1'b0, idx);
        cyc(1'b1, 1'b1, d);
    endtask
    task automatic get(input logic [7:0] idx, output logic [7:0] d, output logic ok);
        cyc(1'b1, 1'b0, idx);
        cyc(1'b0, 1'b1, 8'h00);
        ok = host_rvalid;
        d = host_rdata;
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        sys_clk, resetn, main_power_good, host_wr, host_rd, host_addr, host_rvalid;
    logic        ec_we, ec_rd, ec_rvalid, controller_irq_enable, alert_pin_select, block_idle;
    logic        controller_command_irq, host_serial_irq_source, host_mgmt_alert_source;
    logic        mgmt_alert_serirq_n, system_mgmt_alert_pin_out, system_mgmt_alert_pin_oe;
    logic [7:0]  host_wdata, host_rdata;
    logic [8:0]  ec_addr;
    logic [3:0]  ec_be;
    logic [31:0] ec_wdata, ec_rdata;
    int          error_cnt = 0;
    int          comparisons = 0;
    // open-drain alert line with its pull-up
    wire         alert_line = system_mgmt_alert_pin_oe ? system_mgmt_alert_pin_out : 1'b1;

    host_ec_mailbox host_ec_mailbox_inst (.sys_clk(sys_clk), .resetn(resetn),
        .main_power_good(main_power_good), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .ec_we(ec_we), .ec_rd(ec_rd), .ec_addr(ec_addr),
        .ec_be(ec_be), .ec_wdata(ec_wdata), .ec_rdata(ec_rdata), .ec_rvalid(ec_rvalid),
        .controller_irq_enable(controller_irq_enable), .alert_pin_select(alert_pin_select),
        .controller_command_irq(controller_command_irq),
        .host_serial_irq_source(host_serial_irq_source),
        .host_mgmt_alert_source(host_mgmt_alert_source), .mgmt_alert_serirq_n(mgmt_alert_serirq_n),
        .system_mgmt_alert_pin_out(system_mgmt_alert_pin_out),
        .system_mgmt_alert_pin_oe(system_mgmt_alert_pin_oe), .block_idle(block_idle));
    host_cpu_model host_cpu_model_inst (.sys_clk(sys_clk), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // one controller word cycle; for a read, d is the expected word
    task automatic ec_cyc(input logic wr, input logic [8:0] a, input logic [3:0] be,
                          input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        {ec_we, ec_rd, ec_addr, ec_be, ec_wdata} = {wr, !wr, a, be, d};
        @(posedge sys_clk);
        #1;
        {ec_we, ec_rd} = 2'b00;
        if (!wr) begin
            check("ec_rvalid", ec_rvalid, 32'h1);
            check("ec_rdata", ec_rdata, d);
        end
    endtask
    task automatic hchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host_cpu_model_inst.get(idx, d, ok);
        check("host_rvalid", ok, 32'h1);
        check("host_rdata", d, exp);
    endtask
    // reset state, then mailbox bytes crossing both ways and holes in the map
    task automatic t_mailbox();
        logic [7:0] bad [3] = '{8'h04, 8'h0f, 8'h30};
        check("serirq_n", mgmt_alert_serirq_n, 32'h1);
        check("alert_line", alert_line, 32'h1);
        for (int a = 0; a < 12; a++) begin
            ec_cyc(1'b0, 9'h100 + {a[6:0], 2'b00}, 4'h0, 32'h0);
        end
        for (int i = 0; i < 32; i++) begin
            host_cpu_model_inst.put(8'h10 + i[7:0], 8'ha0 + i[7:0]);
        end
        for (int n = 0; n < 32; n += 4) begin
            ec_cyc(1'b0, 9'h110 + n[8:0], 4'h0, 32'h0302_0100 * 1 + {4{8'ha0 + n[7:0]}});
        end
        ec_cyc(1'b1, 9'h12c, 4'hf, 32'h4433_2211);
        for (int k = 0; k < 4; k++) begin
            hchk(8'h2c + k[7:0], 8'h11 * (k[7:0] + 8'h01));
        end
        ec_cyc(1'b1, 9'h000, 4'h1, 32'h0000_0013);
        ec_cyc(1'b1, 9'h000, 4'h2, 32'h0000_7700);
        hchk(8'h13, 8'h77);
        foreach (bad[j]) begin
            host_cpu_model_inst.put(bad[j], 8'h5a);
            hchk(bad[j], 8'h00);
        end
    endtask
    // host command: masked first, then unmasked, read-clear and completion code
    task automatic t_host_cmd();
        host_cpu_model_inst.put(8'h00, 8'h33);
        step(3);
        check("cmd_irq", controller_command_irq, 32'h0);
        controller_irq_enable = 1'b1;
        step(2);
        check("cmd_irq", controller_command_irq, 32'h1);
        ec_cyc(1'b0, 9'h100, 4'h0, 32'h33);
        step(2);
        check("cmd_irq", controller_command_irq, 32'h0);
        ec_cyc(1'b1, 9'h100, 4'h1, 32'hff);
        hchk(8'h00, 8'h00);
    endtask
    // controller command raises the posted event; host completes with ffh
    task automatic t_ec_cmd();
        alert_pin_select = 1'b1;
        ec_cyc(1'b1, 9'h10c, 4'h1, 32'h01);
        ec_cyc(1'b1, 9'h104, 4'h1, 32'h55);
        step(2);
        check("serial_irq", host_serial_irq_source, 32'h1);
        check("alert", host_mgmt_alert_source, 32'h1);
        check("serirq_n", mgmt_alert_serirq_n, 32'h0);
        check("alert_line", alert_line, 32'h0);
        hchk(8'h01, 8'h55);
        host_cpu_model_inst.put(8'h01, 8'hff);
        step(2);
        check("serial_irq", host_serial_irq_source, 32'h0);
        ec_cyc(1'b0, 9'h104, 4'h0, 32'h0);
    endtask
    // software alerts count only where enabled; pin stays off when not selected
    task automatic t_swi();
        alert_pin_select = 1'b0;
        ec_cyc(1'b1, 9'h10c, 4'h1, 32'h04);
        ec_cyc(1'b1, 9'h108, 4'h1, 32'h08);
        step(2);
        check("alert", host_mgmt_alert_source, 32'h0);
        ec_cyc(1'b1, 9'h108, 4'h1, 32'h04);
        step(2);
        check("alert", host_mgmt_alert_source, 32'h1);
        check("alert_line", alert_line, 32'h1);
        host_cpu_model_inst.put(8'h02, 8'h0c);
        step(2);
        check("alert", host_mgmt_alert_source, 32'h0);
    endtask
    // host port held while main power is gone; mailbox contents survive
    task automatic t_power();
        main_power_good = 1'b0;
        step(4);
        host_cpu_model_inst.put(8'h10, 8'h99);
        hchk(8'h10, 8'h00);
        main_power_good = 1'b1;
        step(4);
        hchk(8'h10, 8'ha0);
        // a mid-run system reset clears what the power loss kept
        resetn = 1'b0;
        step(3);
        resetn = 1'b1;
        step(3);
        ec_cyc(1'b0, 9'h110, 4'h0, 32'h0);
        check("block_idle", block_idle, 32'h0);
        step(1);
        check("block_idle", block_idle, 32'h1);
    endtask
    initial begin
        {resetn, main_power_good, controller_irq_enable, alert_pin_select} = 4'b0100;
        {ec_we, ec_rd, ec_addr, ec_be, ec_wdata} = 47'h0;
        step(3);
        resetn = 1'b1;
        step(3);
        t_mailbox();
        t_host_cmd();
        t_ec_cmd();
        t_swi();
        t_power();
        print_verdict();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
